// ---- hw/irq_ctrl_pkg.sv ----
package irq_ctrl_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_TIMER_EN    = 8'h04;
  localparam logic [7:0] OFF_CAPCOMP_EN  = 8'h08;
  localparam logic [7:0] OFF_FLAGS       = 8'h0C;
  localparam logic [7:0] OFF_STATUS      = 8'h10;
  localparam logic [7:0] OFF_MASK        = 8'h14;
  localparam logic [7:0] OFF_SAVED_PC    = 8'h18;

  // Control register fields.
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_GROUP_EN  = 1;
  // Flag register layout: four peripheral events.
  localparam int FLG_TMR_OVF  = 0;
  localparam int FLG_TMR_MAT  = 1;
  localparam int FLG_CCP_ONE  = 2;
  localparam int FLG_CCP_TWO  = 3;
  localparam int NUM_EVENTS   = 4;
  // Status events for the bus interrupt.
  localparam int ST_VECTOR = 0;
  localparam int ST_RETURN = 1;

  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam int CTX_W = 32;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_ACCEPT  = 2'b01,
    ST_SERVICE = 2'b11
  } svc_state_t;

endpackage

// ---- hw/cpu_interrupt_controller.sv ----
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpu_interrupt_controller (
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Peripheral events, one-cycle pulses
  input  wire logic [irq_ctrl_pkg::NUM_EVENTS-1:0] event_pulse,
  // Core sequencer
  input  wire logic                           first_quarter_phase,
  input  wire logic [irq_ctrl_pkg::PC_W-1:0]  core_pc,
  input  wire logic [irq_ctrl_pkg::CTX_W-1:0] core_context,
  input  wire logic                           return_from_service,
  output logic                                flush_prefetch,
  output logic                                pc_load,
  output logic [irq_ctrl_pkg::PC_W-1:0]       pc_load_value,
  output logic                                context_restore,
  output logic [irq_ctrl_pkg::CTX_W-1:0]      shadow_context,
  output logic                                core_irq_request,
  // Bus interrupt
  output logic                                irq
);

  logic                                 global_irq_enable;
  logic                                 periph_group_enable;
  logic [7:0]                           timer_irq_enable;
  logic [7:0]                           capture_compare_irq_enable;
  logic [irq_ctrl_pkg::NUM_EVENTS-1:0]  periph_flag_regs;
  logic [irq_ctrl_pkg::NUM_EVENTS-1:0]  event_enable;
  logic [1:0]                           status;
  logic [1:0]                           mask;
  logic [irq_ctrl_pkg::PC_W-1:0]        saved_pc;
  irq_ctrl_pkg::svc_state_t             state;
  logic                                 next_request;
  logic                                 take_irq;
  logic                                 aw_held;
  logic                                 w_held;
  logic [7:0]                           aw_addr;
  logic [31:0]                          w_data;
  logic [3:0]                           w_strb;
  logic                                 do_write;
  logic                                 do_read;
  logic [31:0]                          read_value;
  logic                                 read_ok;
  logic                                 write_ok;
  logic [irq_ctrl_pkg::NUM_EVENTS-1:0]  flag_write;
  logic                                 status_read;

  assign event_enable = {capture_compare_irq_enable[1:0], timer_irq_enable[1:0]};

  always_comb
  begin
    next_request = global_irq_enable & periph_group_enable &
                   (|(periph_flag_regs & event_enable));
  end

  assign take_irq = (state == irq_ctrl_pkg::ST_RUN) & first_quarter_phase & next_request;

  // Write channel: address and data are taken independently.
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign do_read  = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irq_ctrl_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_ok ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    case (aw_addr)
      irq_ctrl_pkg::OFF_CONTROL,
      irq_ctrl_pkg::OFF_TIMER_EN,
      irq_ctrl_pkg::OFF_CAPCOMP_EN,
      irq_ctrl_pkg::OFF_FLAGS,
      irq_ctrl_pkg::OFF_MASK:       write_ok = 1'b1;
      default:                      write_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    read_ok    = 1'b1;
    read_value = 32'h0000_0000;
    case (s_axi_araddr)
      irq_ctrl_pkg::OFF_CONTROL:
        read_value = {30'h0, periph_group_enable, global_irq_enable};
      irq_ctrl_pkg::OFF_TIMER_EN:   read_value = {24'h0, timer_irq_enable};
      irq_ctrl_pkg::OFF_CAPCOMP_EN: read_value = {24'h0, capture_compare_irq_enable};
      irq_ctrl_pkg::OFF_FLAGS:      read_value = {28'h0, periph_flag_regs};
      irq_ctrl_pkg::OFF_STATUS:     read_value = {30'h0, status};
      irq_ctrl_pkg::OFF_MASK:       read_value = {30'h0, mask};
      irq_ctrl_pkg::OFF_SAVED_PC:   read_value = {19'h0, saved_pc};
      default:                      read_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irq_ctrl_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~do_read;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_value;
        s_axi_rresp  <= read_ok ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign status_read = do_read & (s_axi_araddr == irq_ctrl_pkg::OFF_STATUS);

  // Enable registers; only the low two bits exist so the rest stay zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_irq_enable           <= 8'h00;
      capture_compare_irq_enable <= 8'h00;
      periph_group_enable        <= 1'b0;
      mask                       <= 2'h0;
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_addr == irq_ctrl_pkg::OFF_TIMER_EN)
        timer_irq_enable <= {6'h00, w_data[1:0]};
      if (aw_addr == irq_ctrl_pkg::OFF_CAPCOMP_EN)
        capture_compare_irq_enable <= {6'h00, w_data[1:0]};
      if (aw_addr == irq_ctrl_pkg::OFF_CONTROL)
        periph_group_enable <= w_data[irq_ctrl_pkg::BIT_GROUP_EN];
      if (aw_addr == irq_ctrl_pkg::OFF_MASK)
        mask <= w_data[1:0];
    end
  end

  // Global enable: hardware acceptance outranks a software write that
  // lands on the same edge, so a vector is never taken with it left set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      global_irq_enable <= 1'b0;
    else if (take_irq)
      global_irq_enable <= 1'b0;
    else if (return_from_service && state == irq_ctrl_pkg::ST_SERVICE)
      global_irq_enable <= 1'b1;
    else if (do_write && w_strb[0] && aw_addr == irq_ctrl_pkg::OFF_CONTROL)
      global_irq_enable <= w_data[irq_ctrl_pkg::BIT_GLOBAL_EN];
  end

  assign flag_write = (do_write && w_strb[0] && aw_addr == irq_ctrl_pkg::OFF_FLAGS) ?
                      ~w_data[irq_ctrl_pkg::NUM_EVENTS-1:0] : '0;

  generate
    for (genvar i = 0; i < irq_ctrl_pkg::NUM_EVENTS; i++)
    begin : g_flag
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          periph_flag_regs[i] <= 1'b0;
        else if (event_pulse[i])
          periph_flag_regs[i] <= 1'b1;
        else if (flag_write[i])
          periph_flag_regs[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= irq_ctrl_pkg::ST_RUN;
    else
    begin
      case (state)
        irq_ctrl_pkg::ST_RUN:
          if (take_irq)
            state <= irq_ctrl_pkg::ST_ACCEPT;
        irq_ctrl_pkg::ST_ACCEPT:
          state <= irq_ctrl_pkg::ST_SERVICE;
        irq_ctrl_pkg::ST_SERVICE:
          if (return_from_service)
            state <= irq_ctrl_pkg::ST_RUN;
        default:
          state <= irq_ctrl_pkg::ST_RUN;
      endcase
    end
  end

  // Core-facing strobes; all registered, one cycle after acceptance or return; core_irq_request one cycle after next_request.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flush_prefetch   <= 1'b0;
      pc_load          <= 1'b0;
      pc_load_value    <= '0;
      context_restore  <= 1'b0;
      shadow_context   <= '0;
      saved_pc         <= '0;
      core_irq_request <= 1'b0;
    end
    else
    begin
      core_irq_request <= next_request;
      flush_prefetch   <= take_irq;
      context_restore  <= 1'b0;
      pc_load          <= 1'b0;
      if (take_irq)
      begin
        pc_load       <= 1'b1;
        pc_load_value <= irq_ctrl_pkg::VECTOR_ADDR;
        saved_pc      <= core_pc;
        shadow_context <= core_context;
      end
      else if (return_from_service && state == irq_ctrl_pkg::ST_SERVICE)
      begin
        pc_load         <= 1'b1;
        pc_load_value   <= saved_pc;
        context_restore <= 1'b1;
      end
    end
  end

  // Bus interrupt status; a read clears, a new event in that cycle wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status <= 2'h0;
      irq    <= 1'b0;
    end
    else
    begin
      status[irq_ctrl_pkg::ST_VECTOR] <= take_irq |
        (status[irq_ctrl_pkg::ST_VECTOR] & ~status_read);
      status[irq_ctrl_pkg::ST_RETURN] <=
        (return_from_service & (state == irq_ctrl_pkg::ST_SERVICE)) |
        (status[irq_ctrl_pkg::ST_RETURN] & ~status_read);
      irq <= |(status & mask);
    end
  end

  // Assertions.
  a_vector_address: assert property (@(posedge aclk) disable iff (!aresetn)
    take_irq |=> pc_load && pc_load_value == irq_ctrl_pkg::VECTOR_ADDR)
    else $error("vector not loaded");
  a_flush_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    flush_prefetch == $past(take_irq))
    else $error("flush not tied to accept");
  a_global_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    take_irq |=> !global_irq_enable && saved_pc == $past(core_pc))
    else $error("accept did not clear enable or push pc");
  a_shadow_save: assert property (@(posedge aclk) disable iff (!aresetn)
    take_irq |=> shadow_context == $past(core_context))
    else $error("context not shadowed");
  a_no_vector_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_irq_enable |-> !take_irq)
    else $error("vector taken with global clear");
  a_return_path: assert property (@(posedge aclk) disable iff (!aresetn)
    (return_from_service && state == irq_ctrl_pkg::ST_SERVICE) |=>
    global_irq_enable && context_restore && pc_load_value == $past(saved_pc))
    else $error("return did not restore");
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    event_pulse[0] |=> periph_flag_regs[0])
    else $error("event lost");
  a_quarter_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    take_irq |-> first_quarter_phase && next_request)
    else $error("request sampled outside first quarter");
  a_enable_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_irq_enable[7:2] == 6'h00 && capture_compare_irq_enable[7:2] == 6'h00)
    else $error("upper enable bits set");
  a_request_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    core_irq_request |-> $past(global_irq_enable && periph_group_enable))
    else $error("request without enables");

  c_accept: cover property (@(posedge aclk) disable iff (!aresetn) take_irq);
  c_return: cover property (@(posedge aclk) disable iff (!aresetn)
    state == irq_ctrl_pkg::ST_SERVICE && return_from_service);
  c_set_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    event_pulse[0] && flag_write[0]);
  c_bus_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule // cpu_interrupt_controller

// ---- verification/core_model.sv ----
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // Controller side
  input  wire logic                                pc_load,
  input  wire logic [irq_ctrl_pkg::PC_W-1:0]       pc_load_value,
  output logic                                     first_quarter_phase,
  output logic [irq_ctrl_pkg::PC_W-1:0]            core_pc,
  output logic [irq_ctrl_pkg::CTX_W-1:0]           core_context,
  output logic                                     return_from_service,
  // Bench command
  input  wire logic                                do_return
);
  logic [1:0] quarter;

  // The context word carries the PC, so a stale shadow copy cannot pass unseen.
  assign core_context        = {3'h5, core_pc, 16'hA5C3};
  assign first_quarter_phase = (quarter == 2'h0);

  // The PC moves late in the cycle, so it is steady across the sampling quarter.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      quarter             <= 2'h0;
      core_pc             <= 13'h0100;
      return_from_service <= 1'b0;
    end
    else
    begin
      quarter             <= quarter + 2'h1;
      return_from_service <= do_return;
      if (pc_load)
        core_pc <= pc_load_value;
      else if (quarter == 2'h2)
        core_pc <= core_pc + 13'h0001;
    end
  end
endmodule // core_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, core_context, shadow_context;
  logic [3:0]  s_axi_wstrb = 4'hF, event_pulse = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, do_return = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        first_quarter_phase, return_from_service, flush_prefetch, pc_load;
  logic        context_restore, core_irq_request, irq, ld_flush, ld_restore, ld_req;
  logic [irq_ctrl_pkg::PC_W-1:0] core_pc, pc_load_value, ld_val, ld_pc, vec_pc;
  int          errors = 0, checked = 0, loads = 0;

  always #20 aclk = ~aclk;

  cpu_interrupt_controller dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .event_pulse, .first_quarter_phase, .core_pc,
    .core_context, .return_from_service, .flush_prefetch, .pc_load, .pc_load_value,
    .context_restore, .shadow_context, .core_irq_request, .irq);

  core_model core (
    .aclk, .aresetn, .pc_load, .pc_load_value, .first_quarter_phase, .core_pc,
    .core_context, .return_from_service, .do_return);

  // Every PC load is logged with the values seen in its own cycle.
  always @(posedge aclk)
  begin
    if (pc_load === 1'b1)
    begin
      loads++;
      ld_val = pc_load_value;
      ld_pc = core_pc;
      ld_flush = flush_prefetch;
      ld_restore = context_restore;
      ld_req = core_irq_request;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write response", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input string what);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("read response", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
    chk(what, exp, s_axi_rdata);
  endtask

  task automatic fire(input logic [3:0] e);
    @(posedge aclk);
    event_pulse <= e;
    @(posedge aclk);
    event_pulse <= 4'h0;
  endtask

  task automatic wait_loads(input int n);
    for (int k = 0; k < 40 && loads < n; k++)
      @(posedge aclk);
    chk("vector loads", 32'(n), 32'(loads));
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), 32'h0, irq_ctrl_pkg::RESP_OKAY, "reset value");
    chk("irq after reset", 32'h0, 32'(irq));
  endtask

  task automatic t_enable_regs();
    wr(irq_ctrl_pkg::OFF_TIMER_EN, 32'hFFFFFFFF, irq_ctrl_pkg::RESP_OKAY);
    rd(irq_ctrl_pkg::OFF_TIMER_EN, 32'h3, irq_ctrl_pkg::RESP_OKAY, "timer en");
    wr(irq_ctrl_pkg::OFF_CAPCOMP_EN, 32'hFE, irq_ctrl_pkg::RESP_OKAY);
    rd(irq_ctrl_pkg::OFF_CAPCOMP_EN, 32'h2, irq_ctrl_pkg::RESP_OKAY, "capcomp");
    wr(irq_ctrl_pkg::OFF_CAPCOMP_EN, 32'h1, irq_ctrl_pkg::RESP_OKAY);
    rd(irq_ctrl_pkg::OFF_CAPCOMP_EN, 32'h1, irq_ctrl_pkg::RESP_OKAY, "capcomp");
    wr(8'h3C, 32'h1, irq_ctrl_pkg::RESP_SLVERR);
    rd(8'h3C, 32'h0, irq_ctrl_pkg::RESP_SLVERR, "unmapped read");
    wr(irq_ctrl_pkg::OFF_SAVED_PC, 32'h1, irq_ctrl_pkg::RESP_SLVERR);
  endtask

  task automatic t_pending_accept();
    wr(irq_ctrl_pkg::OFF_TIMER_EN, 32'h1, irq_ctrl_pkg::RESP_OKAY);
    wr(irq_ctrl_pkg::OFF_MASK, 32'h1, irq_ctrl_pkg::RESP_OKAY);
    fire(4'hF);
    rd(irq_ctrl_pkg::OFF_FLAGS, 32'hF, irq_ctrl_pkg::RESP_OKAY, "flags ungated");
    wr(irq_ctrl_pkg::OFF_CONTROL, 32'h1, irq_ctrl_pkg::RESP_OKAY);
    repeat (12) @(posedge aclk);
    chk("loads without group", 32'h0, 32'(loads));
    wr(irq_ctrl_pkg::OFF_CONTROL, 32'h3, irq_ctrl_pkg::RESP_OKAY);
    wait_loads(1);
    vec_pc = ld_pc;
    chk("vector address", 32'h4, 32'(ld_val));
    chk("prefetch flush", 32'h1, 32'(ld_flush));
    chk("request at vector", 32'h1, 32'(ld_req));
    rd(irq_ctrl_pkg::OFF_SAVED_PC, 32'(vec_pc), irq_ctrl_pkg::RESP_OKAY, "pushed pc");
    chk("shadow context", {3'h5, vec_pc, 16'hA5C3}, shadow_context);
    rd(irq_ctrl_pkg::OFF_CONTROL, 32'h2, irq_ctrl_pkg::RESP_OKAY, "global off");
    chk("irq on vector", 32'h1, 32'(irq));
    rd(irq_ctrl_pkg::OFF_STATUS, 32'h1, irq_ctrl_pkg::RESP_OKAY, "status vector");
    repeat (2) @(posedge aclk);
    chk("irq after status read", 32'h0, 32'(irq));
  endtask

  task automatic t_service_return();
    wr(irq_ctrl_pkg::OFF_FLAGS, 32'h0, irq_ctrl_pkg::RESP_OKAY);
    rd(irq_ctrl_pkg::OFF_FLAGS, 32'h0, irq_ctrl_pkg::RESP_OKAY, "flags clear");
    fire(4'h2);
    repeat (12) @(posedge aclk);
    chk("loads in service", 32'h1, 32'(loads));
    rd(irq_ctrl_pkg::OFF_FLAGS, 32'h2, irq_ctrl_pkg::RESP_OKAY, "service flag");
    wr(irq_ctrl_pkg::OFF_FLAGS, 32'h0, irq_ctrl_pkg::RESP_OKAY);
    @(posedge aclk);
    do_return <= 1'b1;
    @(posedge aclk);
    do_return <= 1'b0;
    wait_loads(2);
    chk("return address", 32'(vec_pc), 32'(ld_val));
    chk("context restore", 32'h1, 32'(ld_restore));
    chk("flush on return", 32'h0, 32'(ld_flush));
    chk("request on return", 32'h0, 32'(ld_req));
    rd(irq_ctrl_pkg::OFF_CONTROL, 32'h3, irq_ctrl_pkg::RESP_OKAY, "global on");
    repeat (12) @(posedge aclk);
    chk("loads after return", 32'h2, 32'(loads));
    chk("masked return irq", 32'h0, 32'(irq));
    rd(irq_ctrl_pkg::OFF_STATUS, 32'h2, irq_ctrl_pkg::RESP_OKAY, "status return");
  endtask

  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_enable_regs();
    t_pending_accept();
    t_service_return();
    report_and_stop();
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule // tb
